/* File: rtl/smr_pkg.sv */
// Constants and carrier types shared by the supply monitor two block.
// Function
// RULE1: Compare status readable only with both enables set and start-up delay elapsed.
// RULE2: Software enables common, then detector two, waits, then configures in order.
// RULE3: Two-bit field in monitor two control selects the filter sampling clock.
// RULE4: Filter-disable bit 0 runs the digital filter, 1 bypasses it.
// RULE5: Action-select 0 raises the interrupt, 1 raises the monitor two reset.
// RULE6: Software sets timing-select to 1 when the reset action is chosen.
// RULE7: Software starts the low-speed oscillator before enabling a filtered request.
// RULE8: Software waits three sampling clocks before request enable when filtering.
// RULE9: Interrupt or reset is issued only while the request enable bit is 1.
// RULE10: While request enable is 0, select, filter and action fields load together.
// RULE11: No interrupt for a crossing seen while request enable is still 0.
// RULE12: Detect flag sets for crossings before request enable, without an interrupt.
// RULE13: Software reads or clears the detect flag after enabling the request.
// RULE14: Detect flag marks a threshold passage and is cleared by writing 0.
// RULE15: Software disables the filter when using monitor two to leave stop mode.
// RULE16: A monitor two reset sets the reset cause bit to 1.
// RULE17: Supply monitor interrupts are non-maskable.
// RULE18: Watchdog, oscillator, monitor one and two interrupts share one vector.
// RULE19: Handler reads each detect flag, then writes 0 to the monitor flags.
// RULE20: With both enables set the main supply is watched for threshold passage.
// RULE21: Filtered comparator change accepted after three equal consecutive samples.
`default_nettype none

package smr_pkg;

	// ----------------------------------------
	// Register map, byte addresses
	// ----------------------------------------
	localparam logic [4:0] OFS_MONITOR_ENABLE  = 5'h00;
	localparam logic [4:0] OFS_DETECTOR_ENABLE = 5'h04;
	localparam logic [4:0] OFS_DETECTOR_STATUS = 5'h08;
	localparam logic [4:0] OFS_MONITOR_TWO_CTL = 5'h0C;
	localparam logic [4:0] OFS_RESET_CAUSE     = 5'h10;
	localparam logic [4:0] OFS_CLOCK_CTL_ONE   = 5'h14;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int POS_COMMON_EN  = 0;
	localparam int POS_DET_TWO_EN = 0;
	localparam int POS_CMP_STATUS = 0;
	localparam int POS_REQ_EN     = 0;
	localparam int POS_FILT_DIS   = 1;
	localparam int POS_DET_FLAG   = 2;
	localparam int POS_CLK_SEL_LO = 4;
	localparam int POS_CLK_SEL_HI = 5;
	localparam int POS_ACTION     = 6;
	localparam int POS_TIMING     = 7;
	localparam int POS_RST_CAUSE  = 0;
	localparam int POS_OSC_STOP   = 0;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic       RST_OSC_STOP = 1'h0;
	localparam logic       RST_FILT_DIS = 1'h1;
	localparam logic [1:0] RST_CLK_SEL  = 2'h0;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS      = 25;
	localparam int STARTUP_DELAY_NS   = 100000;
	localparam int STARTUP_DELAY_CYC  =
		(STARTUP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FILTER_SAMPLES     = 3;
	localparam int DIV_BITS           = 3;

	// ----------------------------------------
	// Carrier types
	// ----------------------------------------
	typedef struct packed {
		logic       timing_sel;
		logic       action_sel;
		logic [1:0] clk_sel;
		logic       detect_flag;
		logic       filter_dis;
		logic       req_en;
	} smr_ctrl_type;

	typedef enum logic [1:0] {
		DET_OFF,
		DET_WARM,
		DET_ON
	} smr_phase_type;

endpackage

`default_nettype wire

/* File: rtl/smr_sample_div.sv */
// Sampling clock divider for the digital filter, fed by low-speed oscillator ticks.
`default_nettype none

module smr_sample_div (
	input  wire logic       mclk,
	input  wire logic       rstn,
	input  wire logic       osc_tick,
	input  wire logic       osc_run,
	input  wire logic [1:0] clk_sel,
	output logic            sample_tick
);

	typedef struct packed {
		logic [smr_pkg::DIV_BITS-1:0] cnt;
		logic                         tick;
	} smr_div_type;

	smr_div_type st;
	smr_div_type next_st;
	logic [smr_pkg::DIV_BITS-1:0] mask;

	always_comb begin
		next_st = st;
		mask = smr_pkg::DIV_BITS'((4'h1 << clk_sel) - 4'h1);
		next_st.tick = 1'b0;
		if (osc_tick && osc_run) begin // [RULE3]
			next_st.cnt = st.cnt + 3'h1;
			next_st.tick = ((st.cnt & mask) == mask);
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign sample_tick = st.tick;

endmodule

`default_nettype wire

/* File: rtl/smr_filter.sv */
// Digital noise filter: a level passes after three equal samples, or at once when bypassed.
`default_nettype none

module smr_filter (
	input  wire logic mclk,
	input  wire logic rstn,
	input  wire logic raw,
	input  wire logic sample_tick,
	input  wire logic bypass,
	output logic      level
);

	typedef struct packed {
		logic [smr_pkg::FILTER_SAMPLES-1:0] smp;
		logic                               lvl;
	} smr_filt_type;

	smr_filt_type st;
	smr_filt_type next_st;
	logic [smr_pkg::FILTER_SAMPLES-1:0] shifted;

	always_comb begin
		next_st = st;
		shifted = {st.smp[smr_pkg::FILTER_SAMPLES-2:0], raw};
		if (bypass) begin // [RULE4]
			next_st.lvl = raw;
			next_st.smp = {smr_pkg::FILTER_SAMPLES{raw}};
		end else if (sample_tick) begin
			next_st.smp = shifted;
			if (&shifted) begin // [RULE21]
				next_st.lvl = 1'b1;
			end else if (~|shifted) begin
				next_st.lvl = 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign level = st.lvl;

endmodule

`default_nettype wire

/* File: rtl/smr_top.sv */
// Supply monitor two: enables, filter, detect flag, non-maskable interrupt and reset request.
`default_nettype none

module smr_top #(
	parameter int STARTUP_CYC = smr_pkg::STARTUP_DELAY_CYC
) (
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        cmp_above,
	input  wire logic        osc_tick,
	input  wire logic        wdt_irq,
	input  wire logic        osc_det_irq,
	input  wire logic        mon_one_irq,
	output logic             shared_nmi,
	output logic             mon_two_nmi,
	output logic             mon_two_reset_req,
	output logic             osc_enable
);

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	if (STARTUP_CYC < 1 || STARTUP_CYC > 65535) begin : g_bad_startup
		$error("STARTUP_CYC out of range");
	end
	if (smr_pkg::FILTER_SAMPLES < 2) begin : g_bad_samples
		$error("FILTER_SAMPLES below two");
	end
	if (smr_pkg::DIV_BITS < 3) begin : g_bad_divider
		$error("DIV_BITS cannot reach the slowest sampling clock");
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic                  wait_req;
		logic [7:0]            rdata;
		logic                  common_en;
		logic                  det_two_en;
		smr_pkg::smr_ctrl_type ctrl;
		logic                  osc_stop;
		logic                  osc_on;
		logic                  rst_cause;
		smr_pkg::smr_phase_type phase;
		logic [15:0]           cnt;
		logic                  status;
		logic                  prev;
		logic                  nmi;
		logic                  rst_req;
		logic                  vec;
	} smr_top_state_type;

	smr_top_state_type st;
	smr_top_state_type next_st;

	// ----------------------------------------
	// Reset value
	// ----------------------------------------
	localparam smr_top_state_type ST_RESET = '{
		wait_req:   1'b1,
		rdata:      8'h00,
		common_en:  1'b0,
		det_two_en: 1'b0,
		ctrl:       '{
			timing_sel:  1'b0,
			action_sel:  1'b0,
			clk_sel:     smr_pkg::RST_CLK_SEL,
			detect_flag: 1'b0,
			filter_dis:  smr_pkg::RST_FILT_DIS,
			req_en:      1'b0
		},
		osc_stop:   smr_pkg::RST_OSC_STOP,
		osc_on:     !smr_pkg::RST_OSC_STOP,
		rst_cause:  1'b0,
		phase:      smr_pkg::DET_OFF,
		cnt:        16'h0000,
		status:     1'b0,
		prev:       1'b0,
		nmi:        1'b0,
		rst_req:    1'b0,
		vec:        1'b0
	};

	logic       filt_level;
	logic       sample_tick;
	logic       wr_ok;
	logic       rd_ok;
	logic [7:0] wd;
	logic       enabled;
	logic       rise;
	logic       fall;
	logic       hit;

	// ----------------------------------------
	// Filter path
	// ----------------------------------------
	smr_sample_div u_div (
		.mclk        (mclk),
		.rstn        (rstn),
		.osc_tick    (osc_tick),
		.osc_run     (!st.osc_stop),
		.clk_sel     (st.ctrl.clk_sel),
		.sample_tick (sample_tick)
	);

	smr_filter u_filt (
		.mclk        (mclk),
		.rstn        (rstn),
		.raw         (cmp_above),
		.sample_tick (sample_tick),
		.bypass      (st.ctrl.filter_dis),
		.level       (filt_level)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		wd = avs_writedata[7:0];
		wr_ok = avs_write && !st.wait_req && avs_byteenable[0];
		rd_ok = avs_read && st.wait_req;
		enabled = st.common_en && st.det_two_en; // [RULE20]
		rise = 1'b0;
		fall = 1'b0;
		hit = 1'b0;

		// One wait state per access, then a single-cycle acknowledge.
		next_st.wait_req = !((avs_read || avs_write) && st.wait_req);

		// ----------------------------------------
		// Detector start-up sequencing
		// ----------------------------------------
		case (st.phase)
			smr_pkg::DET_OFF: begin
				next_st.cnt = '0;
				if (enabled) begin
					next_st.phase = smr_pkg::DET_WARM;
				end
			end
			smr_pkg::DET_WARM: begin
				next_st.cnt = st.cnt + 16'h1;
				if (!enabled) begin
					next_st.phase = smr_pkg::DET_OFF;
				end else if (st.cnt >= 16'(STARTUP_CYC - 1)) begin // [RULE1]
					next_st.phase = smr_pkg::DET_ON;
				end
			end
			smr_pkg::DET_ON: begin
				if (!enabled) begin
					next_st.phase = smr_pkg::DET_OFF;
				end
			end
			default: begin
				next_st.phase = smr_pkg::DET_OFF;
			end
		endcase

		// ----------------------------------------
		// Threshold passage detection on the filtered level
		// ----------------------------------------
		next_st.nmi = 1'b0;
		next_st.rst_req = 1'b0;
		if (st.phase == smr_pkg::DET_ON) begin
			next_st.status = filt_level; // [RULE1]
			next_st.prev = filt_level;
			rise = filt_level && !st.prev; // [RULE20]
			fall = !filt_level && st.prev;
			hit = st.ctrl.timing_sel ? fall : rise;
		end else begin
			next_st.status = 1'b0;
			// Previous level follows while inactive, so enabling raises no false passage.
			next_st.prev = filt_level;
		end

		// ----------------------------------------
		// Register writes
		// ----------------------------------------
		if (wr_ok) begin
			case (avs_address)
				smr_pkg::OFS_MONITOR_ENABLE: begin
					next_st.common_en = wd[smr_pkg::POS_COMMON_EN];
				end
				smr_pkg::OFS_DETECTOR_ENABLE: begin
					next_st.det_two_en = wd[smr_pkg::POS_DET_TWO_EN];
				end
				smr_pkg::OFS_MONITOR_TWO_CTL: begin
					next_st.ctrl.req_en = wd[smr_pkg::POS_REQ_EN];
					if (!wd[smr_pkg::POS_DET_FLAG]) begin // [RULE14]
						next_st.ctrl.detect_flag = 1'b0;
					end
					// Fields are frozen while requests are live to avoid glitching the path.
					if (!st.ctrl.req_en) begin // [RULE10]
						next_st.ctrl.filter_dis = wd[smr_pkg::POS_FILT_DIS];
						next_st.ctrl.clk_sel = {wd[smr_pkg::POS_CLK_SEL_HI],
							wd[smr_pkg::POS_CLK_SEL_LO]};
						next_st.ctrl.action_sel = wd[smr_pkg::POS_ACTION];
						next_st.ctrl.timing_sel = wd[smr_pkg::POS_TIMING];
					end
				end
				smr_pkg::OFS_RESET_CAUSE: begin
					if (!wd[smr_pkg::POS_RST_CAUSE]) begin
						next_st.rst_cause = 1'b0;
					end
				end
				smr_pkg::OFS_CLOCK_CTL_ONE: begin
					next_st.osc_stop = wd[smr_pkg::POS_OSC_STOP];
				end
				default: begin
				end
			endcase
		end

		// The pin enable is a flop of its own, so the output carries no inverter.
		next_st.osc_on = !next_st.osc_stop;

		// ----------------------------------------
		// Request generation
		// ----------------------------------------
		// Hardware set wins over a software clear in the same cycle.
		if (hit) begin
			next_st.ctrl.detect_flag = 1'b1; // [RULE12] [RULE14]
			if (st.ctrl.req_en) begin // [RULE9] [RULE11]
				if (st.ctrl.action_sel) begin // [RULE5]
					next_st.rst_req = 1'b1;
					next_st.rst_cause = 1'b1; // [RULE16]
				end else begin
					next_st.nmi = 1'b1;
				end
			end
		end

		// Shared vector carries no mask: nothing in this block can block it.
		next_st.vec = next_st.nmi || wdt_irq || osc_det_irq || mon_one_irq; // [RULE17] [RULE18]

		// ----------------------------------------
		// Register reads
		// ----------------------------------------
		if (rd_ok) begin
			next_st.rdata = 8'h00;
			case (avs_address)
				smr_pkg::OFS_MONITOR_ENABLE: begin
					next_st.rdata[smr_pkg::POS_COMMON_EN] = st.common_en;
				end
				smr_pkg::OFS_DETECTOR_ENABLE: begin
					next_st.rdata[smr_pkg::POS_DET_TWO_EN] = st.det_two_en;
				end
				smr_pkg::OFS_DETECTOR_STATUS: begin
					// Status drops at once with either enable, before the phase falls back.
					next_st.rdata[smr_pkg::POS_CMP_STATUS] = st.status && enabled; // [RULE1]
				end
				smr_pkg::OFS_MONITOR_TWO_CTL: begin
					next_st.rdata[smr_pkg::POS_REQ_EN] = st.ctrl.req_en;
					next_st.rdata[smr_pkg::POS_FILT_DIS] = st.ctrl.filter_dis;
					next_st.rdata[smr_pkg::POS_DET_FLAG] = st.ctrl.detect_flag;
					next_st.rdata[smr_pkg::POS_CLK_SEL_LO] = st.ctrl.clk_sel[0];
					next_st.rdata[smr_pkg::POS_CLK_SEL_HI] = st.ctrl.clk_sel[1];
					next_st.rdata[smr_pkg::POS_ACTION] = st.ctrl.action_sel;
					next_st.rdata[smr_pkg::POS_TIMING] = st.ctrl.timing_sel;
				end
				smr_pkg::OFS_RESET_CAUSE: begin
					next_st.rdata[smr_pkg::POS_RST_CAUSE] = st.rst_cause;
				end
				smr_pkg::OFS_CLOCK_CTL_ONE: begin
					next_st.rdata[smr_pkg::POS_OSC_STOP] = st.osc_stop;
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			st <= ST_RESET;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign avs_readdata = {24'h000000, st.rdata};
	assign avs_waitrequest = st.wait_req;
	assign shared_nmi = st.vec;
	assign mon_two_nmi = st.nmi;
	assign mon_two_reset_req = st.rst_req;
	assign osc_enable = st.osc_on;

endmodule

`default_nettype wire

/* File: verification/smr_monitor.sv */
// Concurrent checks on the ports of the supply monitor two block.
`default_nettype none

module smr_monitor #(
	parameter int STARTUP_CYC = smr_pkg::STARTUP_DELAY_CYC
) (
	input wire logic        mclk,
	input wire logic        rstn,
	input wire logic [4:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        cmp_above,
	input wire logic        osc_tick,
	input wire logic        wdt_irq,
	input wire logic        osc_det_irq,
	input wire logic        mon_one_irq,
	input wire logic        shared_nmi,
	input wire logic        mon_two_nmi,
	input wire logic        mon_two_reset_req,
	input wire logic        osc_enable
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);

	// ----------------------------------------
	// Shadows of the written control bits
	// ----------------------------------------
	// The action bit only loads while the request is off, as the block does.
	logic com_sh, det_sh, req_sh, act_sh, stp_sh, wr_ok;
	assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			{com_sh, det_sh, req_sh, act_sh, stp_sh} <= 5'h00;
		end else if (wr_ok) begin
			case (avs_address)
				5'h00: com_sh <= avs_writedata[0];
				5'h04: det_sh <= avs_writedata[0];
				5'h0C: begin
					req_sh <= avs_writedata[0];
					if (!req_sh) act_sh <= avs_writedata[6];
				end
				5'h14: stp_sh <= avs_writedata[0];
				default: ;
			endcase
		end
	end

	// Counts cycles since both enables came on, saturating just past the warm-up.
	int on_cyc;
	always_ff @(posedge mclk) begin
		if (!rstn || !(com_sh && det_sh)) begin
			on_cyc <= 0;
		end else if (on_cyc <= STARTUP_CYC) begin
			on_cyc <= on_cyc + 1;
		end
	end

	chk_warm_quiet: assert property (
		(mon_two_nmi || mon_two_reset_req) |-> on_cyc > STARTUP_CYC)
		else $error("request pulse before detector warm-up ended");
	chk_req_gate: assert property (
		(mon_two_nmi || mon_two_reset_req) |-> $past(req_sh))
		else $error("request pulse without request enable");
	chk_irq_action: assert property (mon_two_nmi |-> !act_sh)
		else $error("interrupt pulse with reset action");
	chk_reset_action: assert property (mon_two_reset_req |-> act_sh)
		else $error("reset pulse with interrupt action");
	chk_nmi_shared: assert property (mon_two_nmi |-> shared_nmi)
		else $error("monitor interrupt missing on shared vector");
	chk_other_src: assert property (
		(wdt_irq || osc_det_irq || mon_one_irq) |=> shared_nmi)
		else $error("other source missing on shared vector");
	chk_status_gate: assert property (
		(avs_read && !avs_waitrequest && avs_address == 5'h08 && !(com_sh && det_sh))
		|-> avs_readdata == 32'h00000000)
		else $error("compare status visible while disabled");
	chk_pulse_once: assert property ($rose(mon_two_nmi) |=> !mon_two_nmi)
		else $error("interrupt pulse longer than one cycle");
	chk_osc_follow: assert property (osc_enable != stp_sh)
		else $error("oscillator enable does not follow stop bit");
endmodule

bind smr_top smr_monitor #(.STARTUP_CYC(STARTUP_CYC)) smr_monitor_inst (.mclk, .rstn,
	.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
	.avs_waitrequest, .cmp_above, .osc_tick, .wdt_irq, .osc_det_irq, .mon_one_irq,
	.shared_nmi, .mon_two_nmi, .mon_two_reset_req, .osc_enable);

`default_nettype wire

/* File: verification/smr_partner.sv */
// Model of the threshold comparator and the low-speed oscillator.
`default_nettype none

module smr_partner #(
	parameter int OSC_DIV = 320
) (
	input  wire logic mclk,
	input  wire logic rstn,
	input  wire logic osc_enable,
	input  wire logic supply_above,
	output logic      cmp_above,
	output logic      osc_tick
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;
	// No hysteresis is modelled, so every supply step is a clean crossing.
	assign cmp_above = supply_above;
	always @(posedge mclk) begin
		if (!rstn || !osc_enable) begin
			cnt <= 0;
			osc_tick <= 1'b0;
		end else begin
			cnt <= (cnt == OSC_DIV - 1) ? 0 : cnt + 1;
			osc_tick <= (cnt == OSC_DIV - 1);
		end
	end
endmodule

`default_nettype wire

/* File: verification/tb_top.sv */
// Register-level testbench of the supply monitor two block.
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// A short warm-up and a fast oscillator keep the run small.
	localparam int SCY = 4;
	localparam int ODIV = 8;
	localparam int LIMIT = 20000;
	logic mclk = 0, rstn = 0, avs_read = 0, avs_write = 0, sup = 1;
	logic cmp_above, osc_tick, shared_nmi, mon_two_nmi, mon_two_reset_req, osc_enable;
	logic avs_waitrequest;
	logic [4:0]  avs_address = 5'h00;
	logic [31:0] avs_writedata = 32'h00000000, avs_readdata;
	logic [3:0]  avs_byteenable = 4'hF;
	logic [2:0]  srcs = 3'h0;
	logic [31:0] r;
	int mismatches = 0, checked = 0, nmi_n = 0, rst_n = 0, cyc = 0, p, n;

	always #12.5 mclk = ~mclk;

	smr_partner #(.OSC_DIV(ODIV)) smr_partner_inst (.mclk, .rstn, .osc_enable,
		.supply_above(sup), .cmp_above, .osc_tick);
	smr_top #(.STARTUP_CYC(SCY)) smr_top_inst (.mclk, .rstn, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
		.cmp_above, .osc_tick, .wdt_irq(srcs[0]), .osc_det_irq(srcs[1]),
		.mon_one_irq(srcs[2]), .shared_nmi, .mon_two_nmi, .mon_two_reset_req, .osc_enable);

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic wrap_up();
		if (mismatches == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", nm, e, g);
			mismatches++;
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		avs_write <= 1'b1;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		r = avs_readdata;
		avs_read <= 1'b0;
		@(posedge mclk);
		chk($sformatf("register %h", a), e, r);
	endtask

	task automatic step(input logic s);
		sup <= s;
		repeat (6) @(posedge mclk);
	endtask

	always @(posedge mclk) begin
		cyc++;
		if (mon_two_nmi === 1'b1) nmi_n++;
		if (mon_two_reset_req === 1'b1) rst_n++;
		if (cyc == LIMIT) begin
			mismatches++;
			wrap_up();
		end
	end

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		rd(5'h0C, 8'h02);
		rd(5'h18, 8'h00);
		rd(5'h08, 8'h00);
		wr(5'h00, 8'h01);
		wr(5'h04, 8'h01);
		rd(5'h08, 8'h00);
		repeat (SCY + 2) @(posedge mclk);
		rd(5'h08, 8'h01);
		wr(5'h0C, 8'h82);
		rd(5'h0C, 8'h82);
		step(1'b0);
		chk("interrupt count", 0, nmi_n);
		rd(5'h0C, 8'h86);
		wr(5'h0C, 8'h82);
		rd(5'h0C, 8'h82);
		step(1'b1);
		wr(5'h0C, 8'h83);
		step(1'b0);
		chk("interrupt count", 1, nmi_n);
		rd(5'h0C, 8'h87);
		wr(5'h0C, 8'hC3);
		rd(5'h0C, 8'h83);
		wr(5'h0C, 8'h00);
		rd(5'h0C, 8'h82);
		wr(5'h0C, 8'hC2);
		step(1'b1);
		wr(5'h0C, 8'hC3);
		step(1'b0);
		chk("reset count", 1, rst_n);
		chk("interrupt count", 1, nmi_n);
		rd(5'h10, 8'h01);
		wr(5'h10, 8'h00);
		rd(5'h10, 8'h00);
		for (int i = 0; i < 3; i++) begin
			srcs <= 3'h1 << i;
			@(posedge mclk);
			srcs <= 3'h0;
			#1;
			chk("shared vector", 1, shared_nmi);
			@(posedge mclk);
		end
		avs_byteenable <= 4'hE;
		wr(5'h14, 8'h01);
		avs_byteenable <= 4'hF;
		chk("oscillator enable", 1, osc_enable);
		wr(5'h14, 8'h01);
		chk("oscillator enable", 0, osc_enable);
		wr(5'h14, 8'h00);
		for (int k = 0; k < 4; k++) begin
			p = ODIV << k;
			wr(5'h0C, 8'h00);
			wr(5'h0C, 8'h80 | 8'(k << 4));
			sup <= 1'b1;
			repeat (4 * p) @(posedge mclk);
			wr(5'h0C, 8'h81 | 8'(k << 4));
			n = nmi_n;
			sup <= 1'b0;
			repeat (2 * p) @(posedge mclk);
			sup <= 1'b1;
			repeat (4 * p) @(posedge mclk);
			chk("filtered glitch", n, nmi_n);
			sup <= 1'b0;
			repeat (4 * p) @(posedge mclk);
			chk("filtered fall", n + 1, nmi_n);
		end
		sup <= 1'b1;
		repeat (4 * p) @(posedge mclk);
		rd(5'h08, 8'h01);
		wr(5'h04, 8'h00);
		rd(5'h08, 8'h00);
		wrap_up();
	end
endmodule

`default_nettype wire
